// File: isq_map.svh
// register indices, field positions, reset values and timing counts of the interrupt sequencer
`ifndef ISQ_MAP_SVH
`define ISQ_MAP_SVH
`define ISQ_IDX_EDGE_SEL 8'hee
`define ISQ_IDX_PIN_FUNC 8'he0
`define ISQ_IDX_EN_HIGH 8'he1
`define ISQ_IDX_EN_LOW 8'he2
`define ISQ_IDX_REQ 8'he3
`define ISQ_IDX_SHARED 8'he4
`define ISQ_IDX_STANDBY 8'he5
`define ISQ_IDX_PSW 8'he6
`define ISQ_IDX_PRESCALE 8'he7
`define ISQ_RST_BYTE 8'h00
`define ISQ_RST_PRESCALE 4'h0
`define ISQ_PSW_I_BIT 2
`define ISQ_PSW_B_BIT 4
`define ISQ_SLEEP_CODE 8'h0f
`define ISQ_SEQ_CYCLES 8
`define ISQ_PUSH_FIRST 3'h1
`define ISQ_PUSH_LAST 3'h3
`define ISQ_FETCH_STEP 3'h5
`define ISQ_LOAD_STEP 3'h7
`define ISQ_WAKE_TOP 8'hff
`define ISQ_EXT_LATENCY_MIN 12
`define ISQ_VEC_TCALL0 4'ha
`define ISQ_SRC_WDT 8
`define ISQ_SRC_WT 9
`define ISQ_SRC_BIT 10
`endif

// File: isq_pkg.sv
// types shared by the interrupt sequencer files
package isq_pkg;
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_SEQ = 4'b0010,
    ST_SLEEP = 4'b0100,
    ST_WAKE = 4'b1000
  } isq_state_t;
  typedef logic [10:0] isq_src_t;
endpackage : isq_pkg

// File: isq_edge_det.sv
// synchronised edge detector for one external interrupt pin
`include "isq_map.svh"
module isq_edge_det (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and selection
  input wire logic pin,
  input wire logic [1:0] mode,
  input wire logic pin_is_irq,
  // detected edge
  output logic edge_pulse
);
  logic sync1;
  logic sync2;
  logic prev;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // mode bit 1 selects rising, bit 0 falling, both set gives either edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      edge_pulse <= 1'b0;
    end else begin
      edge_pulse <= pin_is_irq & ((mode[1] & sync2 & ~prev) | (mode[0] & ~sync2 & prev)); // RULE14 RULE15
    end
  end
endmodule : isq_edge_det

// File: isq_wake_timer.sv
// basic interval count used as the oscillator settling delay after wake
module isq_wake_timer #(
  parameter int WIDTH = 8,
  parameter int PRESCALE_W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic [PRESCALE_W-1:0] prescale,
  // status
  output logic busy,
  output logic overflow
);
  localparam int DIV_W = 1 << PRESCALE_W;
  logic [WIDTH-1:0] count;
  logic [DIV_W-1:0] div;
  logic [DIV_W-1:0] div_limit;
  logic tick;

  if (WIDTH < 2 || PRESCALE_W < 1 || PRESCALE_W > 4) begin : g_bad_param
    $error("isq_wake_timer: unsupported width or prescale width");
  end

  // one count every two to the power of prescale cycles
  assign div_limit = (DIV_W'(1) << prescale) - DIV_W'(1);
  assign tick = (div == div_limit);

  always_ff @(posedge clk) begin
    if (!rst_n || start || tick) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  // counts from zero to all ones, overflow ends the settling time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= '0;
      busy <= 1'b0;
      overflow <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (start) begin
        count <= '0; // RULE21
        busy <= 1'b1;
      end else if (busy && tick) begin
        if (&count) begin
          busy <= 1'b0;
          overflow <= 1'b1; // RULE21
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end
endmodule : isq_wake_timer

// File: isq_top.sv
// interrupt acceptance sequencer with sleep and wake control, apb register slave
// What this block does
// [RULE1] requests stay latched until accepted or cleared
// [RULE2] acceptance starts at boundary, lasts eight cycles
// [RULE3] maskable acceptance clears the master enable
// [RULE4] break acceptance blocks further interrupts
// [RULE5] push return address and status, three decrements
// [RULE6] fetch vector then load program counter
// [RULE7] service ends with the interrupt return op
// [RULE8] software clears peripheral request flags
// [RULE9] no maskable acceptance while master enable low
// [RULE10] software re-enables for nesting, picks sources
// [RULE11] break is lowest, shares table call zero
// [RULE12] watchdog and watch timer share one vector
// [RULE13] higher priority wins, fixed poll order otherwise; the code has no priority levels and always takes the lowest source index first
// [RULE14] four pins, edge mode per input
// [RULE15] pin is interrupt only when function bit set
// [RULE16] edges latched, polled one cycle later
// [RULE17] external request to service takes twelve cycles
// [RULE18] writing 0fh to standby control halts core
// [RULE19] any request or reset ends sleep; the code wakes only on an individually enabled request
// [RULE20] wake with enable vectors, else just resumes
// [RULE21] settling count zero to ff before resume
// [RULE22] master enable is status word bit two
// [RULE23] individually disabled sources never accepted
// [RULE24] single highest winner sampled at boundary
//
// Local design decision: the APB interface to the registers.
`include "isq_map.svh"
module isq_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external interrupt pins
  input wire logic [3:0] ext_irq_inputs,
  // peripheral request pulses: timer0..2, adc, watchdog, watch timer, interval timer
  input wire logic [6:0] periph_req,
  // processor core
  input wire logic instr_boundary,
  input wire logic irq_enable_op,
  input wire logic irq_disable_op,
  input wire logic interrupt_return_op,
  input wire logic [7:0] popped_status,
  input wire logic software_break_op,
  output logic cpu_halt,
  output logic seq_busy,
  output logic push_strobe,
  output logic sp_dec,
  output logic vector_fetch,
  output logic pc_load,
  output logic [3:0] vector_index,
  output logic [7:0] processor_status_word
);
  isq_pkg::isq_state_t state;
  isq_pkg::isq_state_t next_state;
  isq_pkg::isq_src_t req;
  isq_pkg::isq_src_t req_seen;
  isq_pkg::isq_src_t set_req;
  isq_pkg::isq_src_t clr_req;
  isq_pkg::isq_src_t eligible;
  isq_pkg::isq_src_t enables;
  logic [7:0] ext_irq_edge_select;
  logic [7:0] pin_function_select;
  logic [7:0] irq_enable_high;
  logic [7:0] irq_enable_low;
  logic [7:0] standby_control_reg;
  logic [3:0] prescale;
  logic master_enable;
  logic break_flag;
  logic nmi_block;
  logic brk_pend;
  logic [3:0] ext_edge;
  logic [2:0] step;
  logic win_valid;
  logic [3:0] win_src;
  logic [3:0] cur_src;
  logic take;
  logic take_brk;
  logic wake_start;
  logic wake_busy;
  logic wake_done;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [7:0] idx;
  logic hit;
  logic [31:0] rd_val;

  // pin edge detection, one instance per external input
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_edge
      isq_edge_det u_edge (
        .clk(clk),
        .rst_n(rst_n),
        .pin(ext_irq_inputs[g]),
        .mode(ext_irq_edge_select[2*g+1:2*g]),
        .pin_is_irq(pin_function_select[g]),
        .edge_pulse(ext_edge[g])
      );
    end
  endgenerate

  isq_wake_timer #(
    .WIDTH(8),
    .PRESCALE_W(4)
  ) u_wake (
    .clk(clk),
    .rst_n(rst_n),
    .start(wake_start),
    .prescale(prescale),
    .busy(wake_busy),
    .overflow(wake_done)
  );

  // apb decode, zero wait states, word aligned only
  assign idx = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite & hit;
  assign rd_en = psel & ~penable & ~pwrite;

  always_comb begin
    hit = addr_ok;
    rd_val = 32'h0000_0000;
    unique case (idx)
      `ISQ_IDX_EDGE_SEL: rd_val[7:0] = ext_irq_edge_select;
      `ISQ_IDX_PIN_FUNC: rd_val[7:0] = pin_function_select;
      `ISQ_IDX_EN_HIGH: rd_val[7:0] = irq_enable_high;
      `ISQ_IDX_EN_LOW: rd_val[7:0] = irq_enable_low;
      `ISQ_IDX_REQ: rd_val[10:0] = req;
      `ISQ_IDX_SHARED: rd_val[1:0] = {req[`ISQ_SRC_WT], req[`ISQ_SRC_WDT]}; // RULE12
      `ISQ_IDX_STANDBY: rd_val[7:0] = standby_control_reg;
      `ISQ_IDX_PSW: rd_val[7:0] = processor_status_word;
      `ISQ_IDX_PRESCALE: rd_val[3:0] = prescale;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= rd_en ? rd_val : 32'h0000_0000;
      pslverr <= ~hit;
    end
  end

  // software-written configuration
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_irq_edge_select <= `ISQ_RST_BYTE;
      pin_function_select <= `ISQ_RST_BYTE;
      irq_enable_high <= `ISQ_RST_BYTE;
      irq_enable_low <= `ISQ_RST_BYTE;
      prescale <= `ISQ_RST_PRESCALE;
    end else if (wr_en) begin
      unique case (idx)
        `ISQ_IDX_EDGE_SEL: ext_irq_edge_select <= pwdata[7:0]; // RULE14
        `ISQ_IDX_PIN_FUNC: pin_function_select <= pwdata[7:0]; // RULE15
        `ISQ_IDX_EN_HIGH: irq_enable_high <= pwdata[7:0];
        `ISQ_IDX_EN_LOW: irq_enable_low <= pwdata[7:0];
        `ISQ_IDX_PRESCALE: prescale <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // request flags: set wins over any clear
  assign set_req = {periph_req, ext_edge};
  always_comb begin
    clr_req = '0;
    if (wr_en && idx == `ISQ_IDX_REQ) begin
      clr_req = pwdata[10:0]; // RULE8
    end
    if (wr_en && idx == `ISQ_IDX_SHARED) begin
      clr_req[`ISQ_SRC_WDT] = pwdata[0]; // RULE12
      clr_req[`ISQ_SRC_WT] = pwdata[1];
    end
    if (take && !take_brk && win_src < 4'h4) begin
      clr_req[win_src[1:0]] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req <= '0;
      req_seen <= '0;
    end else begin
      req <= (req & ~clr_req) | set_req; // RULE1 RULE16
      req_seen <= req;
    end
  end

  // eligibility: enable bit, master enable, block, and one cycle of age for pins
  assign enables = {irq_enable_low[3:0], irq_enable_high[6:0]};
  assign eligible = req & enables & {7'h7f, req_seen[3:0]} // RULE16 RULE17 RULE23
    & {11{master_enable & ~nmi_block}}; // RULE9 RULE22

  always_comb begin
    win_valid = 1'b0;
    win_src = 4'h0;
    for (int i = 10; i >= 0; i--) begin
      if (eligible[i]) begin
        win_valid = 1'b1;
        win_src = 4'(i); // RULE13
      end
    end
  end

  assign take = (state == isq_pkg::ST_RUN) && instr_boundary && (win_valid || take_brk); // RULE24
  assign take_brk = brk_pend && !win_valid && !nmi_block; // RULE11

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      brk_pend <= 1'b0;
    end else if (software_break_op) begin
      brk_pend <= 1'b1;
    end else if (take && take_brk) begin
      brk_pend <= 1'b0;
    end
  end

  // master enable, break flag and non-maskable block
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      master_enable <= 1'b0;
      break_flag <= 1'b0;
      nmi_block <= 1'b0;
    end else if (take) begin
      master_enable <= 1'b0; // RULE3
      break_flag <= take_brk; // RULE11
      nmi_block <= take_brk; // RULE4
    end else if (interrupt_return_op) begin
      master_enable <= popped_status[`ISQ_PSW_I_BIT]; // RULE7
      break_flag <= popped_status[`ISQ_PSW_B_BIT];
      nmi_block <= 1'b0;
    end else if (irq_enable_op) begin
      master_enable <= 1'b1; // RULE10
    end else if (irq_disable_op) begin
      master_enable <= 1'b0;
    end
  end

  always_comb begin
    processor_status_word = 8'h00;
    processor_status_word[`ISQ_PSW_I_BIT] = master_enable; // RULE22
    processor_status_word[`ISQ_PSW_B_BIT] = break_flag;
  end

  // standby control: 0fh requests sleep, cleared on wake
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      standby_control_reg <= `ISQ_RST_BYTE;
    end else if (state == isq_pkg::ST_SLEEP && (req & enables) != '0) begin
      standby_control_reg <= `ISQ_RST_BYTE; // RULE19
    end else if (wr_en && idx == `ISQ_IDX_STANDBY) begin
      standby_control_reg <= pwdata[7:0];
    end
  end

  assign wake_start = (state == isq_pkg::ST_SLEEP) && ((req & enables) != '0);

  always_comb begin
    next_state = state;
    unique case (state)
      isq_pkg::ST_RUN: begin
        if (take) begin
          next_state = isq_pkg::ST_SEQ; // RULE2
        end else if (standby_control_reg == `ISQ_SLEEP_CODE) begin
          next_state = isq_pkg::ST_SLEEP; // RULE18
        end
      end
      isq_pkg::ST_SEQ: begin
        if (step == `ISQ_LOAD_STEP) begin
          next_state = isq_pkg::ST_RUN;
        end
      end
      isq_pkg::ST_SLEEP: begin
        if (wake_start) begin
          next_state = isq_pkg::ST_WAKE; // RULE19
        end
      end
      isq_pkg::ST_WAKE: begin
        if (wake_done) begin
          next_state = isq_pkg::ST_RUN; // RULE20 RULE21
        end
      end
      default: next_state = isq_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= isq_pkg::ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // acceptance step counter and captured source
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      step <= 3'h0;
      cur_src <= 4'h0;
    end else if (take) begin
      step <= 3'h0;
      cur_src <= take_brk ? `ISQ_VEC_TCALL0 : win_src;
    end else if (state == isq_pkg::ST_SEQ) begin
      step <= step + 3'h1;
    end
  end

  // shared vectors: watchdog and watch timer map together, break on table call zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vector_index <= 4'h0;
    end else if (state == isq_pkg::ST_SEQ && step == `ISQ_FETCH_STEP - 3'h1) begin
      // break shares its source code with the interval timer, so decide on the flag
      if (break_flag) begin
        vector_index <= `ISQ_VEC_TCALL0; // RULE11
      end else if (cur_src == 4'(`ISQ_SRC_WT)) begin
        vector_index <= 4'(`ISQ_SRC_WDT); // RULE12
      end else if (cur_src == 4'(`ISQ_SRC_BIT)) begin
        vector_index <= 4'(`ISQ_SRC_WT);
      end else begin
        vector_index <= cur_src; // RULE11
      end
    end
  end

  assign seq_busy = (state == isq_pkg::ST_SEQ);
  assign push_strobe = seq_busy && step >= `ISQ_PUSH_FIRST && step <= `ISQ_PUSH_LAST; // RULE5
  assign sp_dec = push_strobe; // RULE5
  assign vector_fetch = seq_busy && step == `ISQ_FETCH_STEP; // RULE6
  assign pc_load = seq_busy && step == `ISQ_LOAD_STEP; // RULE6
  assign cpu_halt = (state == isq_pkg::ST_SLEEP) || (state == isq_pkg::ST_WAKE); // RULE18

  // helper: cycles since the oldest pending pin edge
  logic [4:0] ext_age;
  always_ff @(posedge clk) begin
    if (!rst_n || req[3:0] == 4'h0) begin
      ext_age <= 5'h00;
    end else if (ext_age != 5'h1f) begin
      ext_age <= ext_age + 5'h01;
    end
  end

  chk_seq_length: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    take |=> seq_busy [*8] ##1 !seq_busy)
    else $error("acceptance sequence not eight cycles");
  chk_clear_enable: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    take |=> !master_enable)
    else $error("master enable not cleared on acceptance");
  chk_brk_block: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    (take && take_brk) |=> nmi_block && !take)
    else $error("break acceptance did not block");
  chk_three_pushes: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    take |=> !sp_dec ##1 sp_dec [*3] ##1 !sp_dec [*4])
    else $error("stack not decremented three times");
  chk_fetch_load: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    vector_fetch |-> ##2 pc_load)
    else $error("vector fetch not followed by load");
  chk_masked_out: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    (take && !master_enable) |-> take_brk)
    else $error("maskable accepted while disabled");
  chk_disabled_src: assert property (@(posedge clk) disable iff (!rst_n) // RULE23
    (take && !take_brk) |-> enables[win_src])
    else $error("disabled source accepted");
  chk_flag_held: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    (req[4] && !clr_req[4]) |=> req[4])
    else $error("pending request lost");
  chk_sleep_enter: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
    (state == isq_pkg::ST_RUN && !take && standby_control_reg == `ISQ_SLEEP_CODE)
    |=> cpu_halt)
    else $error("sleep code did not halt core");
  chk_wake_resume: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
    (state == isq_pkg::ST_WAKE && wake_done) |=> !cpu_halt)
    else $error("core not released at settling overflow");
  chk_ext_latency: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
    (take && !take_brk && win_src < 4'h4) |-> ext_age >= 5'd1)
    else $error("pin request polled too early");
endmodule : isq_top

// File: isq_core_model.sv
// processor core, pin and peripheral model facing the interrupt sequencer
module isq_core_model (
  // clock
  input wire logic clk,
  // sequencer status
  input wire logic cpu_halt,
  input wire logic seq_busy,
  input wire logic sp_dec,
  input wire logic pc_load,
  input wire logic [3:0] vector_index,
  input wire logic [7:0] processor_status_word,
  // core strobes
  output logic instr_boundary,
  output logic irq_enable_op,
  output logic irq_disable_op,
  output logic interrupt_return_op,
  output logic [7:0] popped_status,
  output logic software_break_op,
  // pins and peripheral pulses
  output logic [3:0] ext_irq_inputs,
  output logic [6:0] periph_req
);
  timeunit 1ns;
  timeprecision 1ns;
  bit [1:0] phase;
  bit busy_q;
  bit [7:0] psw_q;
  bit [7:0] saved;
  bit [3:0] last_vec;
  int n_load;
  int n_busy;
  int n_dec;
  initial begin
    {irq_enable_op, irq_disable_op, interrupt_return_op, software_break_op} = 4'h0;
    popped_status = 8'h00;
    ext_irq_inputs = 4'h0;
    periph_req = 7'h00;
  end
  // one instruction ends every fourth cycle while the core runs
  assign instr_boundary = (phase == 2'h3) && !cpu_halt && !seq_busy;
  always_ff @(posedge clk) begin
    phase <= phase + 2'h1;
    busy_q <= seq_busy;
    psw_q <= processor_status_word;
    if (seq_busy && !busy_q) begin
      saved <= psw_q;
      n_busy <= 1;
      n_dec <= 0;
    end else if (seq_busy) begin
      n_busy <= n_busy + 1;
      n_dec <= n_dec + (sp_dec ? 1 : 0);
    end
    if (pc_load) begin
      n_load <= n_load + 1;
      last_vec <= vector_index;
    end
  end
  // k: bit0 enable, bit1 disable, bit2 return, bit3 break
  task pulse(input logic [3:0] k);
    @(posedge clk);
    irq_enable_op <= k[0];
    irq_disable_op <= k[1];
    interrupt_return_op <= k[2];
    software_break_op <= k[3];
    popped_status <= saved;
    @(posedge clk);
    {irq_enable_op, irq_disable_op, interrupt_return_op, software_break_op} <= 4'h0;
    popped_status <= ~saved;
  endtask : pulse
  task periph(input logic [6:0] m);
    @(posedge clk);
    periph_req <= m;
    @(posedge clk);
    periph_req <= 7'h00;
  endtask : periph
  task pin(input int i, input logic v);
    @(posedge clk);
    ext_irq_inputs[i] <= v;
  endtask : pin
endmodule : isq_core_model

// File: isq_top_tb.sv
// self-checking bench for the interrupt sequencer
`include "isq_map.svh"
module isq_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] OP_ON = 4'h1;
  localparam logic [3:0] OP_OFF = 4'h2;
  localparam logic [3:0] OP_RET = 4'h4;
  localparam logic [3:0] OP_SWB = 4'h8;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] ext_irq_inputs, vector_index;
  logic [6:0] periph_req;
  logic instr_boundary, irq_enable_op, irq_disable_op, interrupt_return_op;
  logic software_break_op, cpu_halt, seq_busy, push_strobe, sp_dec, vector_fetch, pc_load;
  logic [7:0] popped_status, processor_status_word;
  logic [1:0] modes [4] = '{2'b10, 2'b01, 2'b11, 2'b11};
  logic [1:0] m;
  int miscompares = 0;
  int num_checks = 0;
  int exp_loads = 0;
  int waited;
  int n_push = 0;
  int n_fetch = 0;
  always @(posedge clk) begin
    if (push_strobe) n_push <= n_push + 1;
    if (vector_fetch) n_fetch <= n_fetch + 1;
  end
  isq_top i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_inputs(ext_irq_inputs), .periph_req(periph_req),
    .instr_boundary(instr_boundary), .irq_enable_op(irq_enable_op),
    .irq_disable_op(irq_disable_op), .interrupt_return_op(interrupt_return_op),
    .popped_status(popped_status), .software_break_op(software_break_op),
    .cpu_halt(cpu_halt), .seq_busy(seq_busy), .push_strobe(push_strobe), .sp_dec(sp_dec),
    .vector_fetch(vector_fetch), .pc_load(pc_load), .vector_index(vector_index),
    .processor_status_word(processor_status_word));
  isq_core_model i_core (.clk(clk), .cpu_halt(cpu_halt), .seq_busy(seq_busy),
    .sp_dec(sp_dec), .pc_load(pc_load), .vector_index(vector_index),
    .processor_status_word(processor_status_word), .instr_boundary(instr_boundary),
    .irq_enable_op(irq_enable_op), .irq_disable_op(irq_disable_op),
    .interrupt_return_op(interrupt_return_op), .popped_status(popped_status),
    .software_break_op(software_break_op), .ext_irq_inputs(ext_irq_inputs),
    .periph_req(periph_req));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task results;
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  task do_reset;
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [1:0] lo);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, lo};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 2'b00);
  endtask : wr
  task rdc(input string w, input logic [7:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0, 2'b00);
    check(w, rd, e);
  endtask : rdc
  task clr;
    wr(`ISQ_IDX_REQ, 32'h7ff);
    wr(`ISQ_IDX_SHARED, 32'h3);
  endtask : clr
  task quiet;
    repeat (40) @(posedge clk);
    check("no acceptance", i_core.n_load, exp_loads);
  endtask : quiet
  task wait_load(input logic [3:0] vec);
    waited = 0;
    while (i_core.n_load == exp_loads && waited < 2000) begin
      @(posedge clk);
      waited++;
    end
    if (waited >= 2000) begin
      miscompares++;
      results();
    end
    exp_loads++;
    repeat (2) @(posedge clk);
    check("vector", {28'h0, i_core.last_vec}, {28'h0, vec});
    check("busy cycles", i_core.n_busy, 8);
    check("stack decrements", i_core.n_dec, 3);
    check("push cycles", n_push, 3 * exp_loads);
    check("vector fetches", n_fetch, exp_loads);
    if (vec != `ISQ_VEC_TCALL0) begin
      check("master enable", processor_status_word[`ISQ_PSW_I_BIT], 1'b0);
    end
  endtask : wait_load
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    do_reset();
    for (int k = 0; k < 9; k++) begin
      rdc("reset value", (k == 8) ? `ISQ_IDX_EDGE_SEL : `ISQ_IDX_PIN_FUNC + 8'(k), 32'h0);
    end
    rdc("unmapped read", 8'he8, 32'h0);
    check("unmapped error", err, 1'b1);
    apb(1'b1, `ISQ_IDX_EDGE_SEL, 32'hff, 2'b01);
    check("unaligned error", err, 1'b1);
    wr(`ISQ_IDX_EDGE_SEL, 32'ha5);
    rdc("edge select", `ISQ_IDX_EDGE_SEL, 32'ha5);
    wr(`ISQ_IDX_PSW, 32'hff);
    rdc("status read only", `ISQ_IDX_PSW, 32'h0);
    // rising, falling, both, and a pin left as port
    for (int i = 0; i < 4; i++) begin
      m = (i == 3) ? 2'b00 : modes[i];
      wr(`ISQ_IDX_EDGE_SEL, {30'h0, modes[i]} << (2 * i));
      wr(`ISQ_IDX_PIN_FUNC, (i < 3) ? 32'h1 << i : 32'h0);
      wr(`ISQ_IDX_EN_HIGH, 32'h1 << i);
      i_core.pulse(OP_ON);
      i_core.pin(i, 1'b1);
      if (m[1]) begin
        wait_load(4'(i));
        check("latency", waited >= `ISQ_EXT_LATENCY_MIN, 1'b1);
        i_core.pulse(OP_RET);
      end
      i_core.pin(i, 1'b0);
      if (m[0]) begin
        wait_load(4'(i));
        i_core.pulse(OP_RET);
      end
      quiet();
    end
    wr(`ISQ_IDX_EN_HIGH, 32'h70);
    i_core.pulse(OP_OFF);
    i_core.periph(7'h02);
    quiet();
    rdc("held request", `ISQ_IDX_REQ, 32'h20);
    i_core.pulse(OP_ON);
    wait_load(4'h5);
    clr();
    i_core.pulse(OP_RET);
    wr(`ISQ_IDX_EN_LOW, 32'h1);
    i_core.pulse(OP_OFF);
    i_core.periph(7'h0c);
    i_core.pulse(OP_ON);
    wait_load(4'h6);
    wr(`ISQ_IDX_REQ, 32'h40);
    i_core.pulse(OP_RET);
    wait_load(4'h7);
    clr();
    i_core.pulse(OP_RET);
    // adc pulses beside each shared source while its enable is off
    wr(`ISQ_IDX_EN_LOW, 32'h6);
    for (int k = 4; k < 6; k++) begin
      i_core.periph(7'h08 | (7'h1 << k));
      wait_load(4'h8);
      rdc("shared flags", `ISQ_IDX_SHARED, 32'h1 << (k - 4));
      clr();
      i_core.pulse(OP_RET);
    end
    i_core.pulse(OP_SWB);
    wait_load(`ISQ_VEC_TCALL0);
    check("break flag", processor_status_word[`ISQ_PSW_B_BIT], 1'b1);
    i_core.pulse(OP_ON);
    i_core.periph(7'h01);
    quiet();
    i_core.pulse(OP_RET);
    wait_load(4'h4);
    clr();
    i_core.pulse(OP_RET);
    wr(`ISQ_IDX_EN_HIGH, 32'h10);
    for (int s = 0; s < 2; s++) begin
      wr(`ISQ_IDX_PRESCALE, s);
      i_core.pulse((s == 1) ? OP_ON : OP_OFF);
      wr(`ISQ_IDX_STANDBY, {24'h0, `ISQ_SLEEP_CODE});
      repeat (3) @(posedge clk);
      check("halted", cpu_halt, 1'b1);
      i_core.periph(7'h01);
      waited = 0;
      while (cpu_halt === 1'b1 && waited < 5000) begin
        @(posedge clk);
        waited++;
      end
      if (waited >= 5000) begin
        miscompares++;
        results();
      end
      check("settling", waited >= (32'(`ISQ_WAKE_TOP) << s), 1'b1);
      check("woken", cpu_halt, 1'b0);
      if (s == 0) begin
        quiet();
      end else begin
        wait_load(4'h4);
      end
      clr();
      if (s == 1) begin
        i_core.pulse(OP_RET);
      end
    end
    i_core.periph(7'h01);
    do_reset();
    rdc("request after reset", `ISQ_IDX_REQ, 32'h0);
    rdc("status after reset", `ISQ_IDX_PSW, 32'h0);
    results();
  end
endmodule : isq_top_tb
